// *** tb/eth_lane_stat_asserts.sv ***
// port checks for the lane, statistics and pause block
`timescale 1ns/1ps
module eth_lane_stat_asserts
   import eth_lane_pkg::*;
(
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_srst,
   // controls and streams
   input wire logic i_mode_50g,
   input wire logic i_wide_user_bus,
   input wire logic i_test_pattern_en,
   input wire tx_word_s i_tx,
   input wire rx_word_s i_rx,
   input wire logic i_tx_pause_req,
   // watched outputs
   input wire logic o_tx_ready,
   input wire logic o_tx_pause_busy,
   input wire logic o_rx_pause_valid,
   input wire logic [3:0] o_rx_lane_valid,
   input wire logic [3:0] o_tx_lane_load,
   input wire stat_s o_stat,
   input wire logic [2:0] o_active_lanes,
   input wire logic o_cfg_error
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_srst);
   a_cfg_error_def: assert property (o_cfg_error == (i_mode_50g & i_wide_user_bus))
      else $error("config error flag wrong");
   a_lane_count: assert property (o_active_lanes == (i_mode_50g ? 3'h2 : 3'h4))
      else $error("active lane count wrong");
   a_rx_bad_frame: assert property (i_rx.valid && i_rx.eop && (i_rx.fcs_err || i_rx.len_err)
      |=> o_stat.rx_bad && !o_stat.rx_good) else $error("errored frame not bad");
   a_rx_good_frame: assert property (i_rx.valid && i_rx.eop && !i_rx.fcs_err && !i_rx.len_err
      |=> o_stat.rx_good && !o_stat.rx_bad) else $error("clean frame not good");
   a_rx_len_stat: assert property (i_rx.valid && i_rx.eop
      |=> o_stat.rx_len_err == $past(i_rx.len_err)) else $error("length stat wrong");
   a_stat_quiet: assert property (!(i_rx.valid && i_rx.eop)
      |=> !o_stat.rx_good && !o_stat.rx_bad) else $error("rx stat without frame end");
   a_pattern_hold: assert property ($past(i_test_pattern_en) && i_test_pattern_en
      |-> !o_tx_ready) else $error("ready during test pattern");
   a_tx_take_load: assert property (o_tx_ready && i_tx.valid |=> $onehot(o_tx_lane_load))
      else $error("taken word not loaded on one lane");
   a_pause_take: assert property (i_tx_pause_req && !o_tx_pause_busy |=> o_tx_pause_busy)
      else $error("pause request not taken");
   a_rx_pause_cause: assert property (o_rx_pause_valid
      |-> $past(i_rx.valid && i_rx.eop && !i_rx.fcs_err && !i_rx.len_err))
      else $error("pause status without good frame end");
   a_lane_pulse: assert property (o_rx_lane_valid[0] |=> !o_rx_lane_valid[0])
      else $error("lane valid longer than one cycle");
   a_narrow_quiet: assert property (i_mode_50g [*4] |-> o_rx_lane_valid[3:2] == 2'h0)
      else $error("inactive lane captured");
   c_rx_pause: cover property (o_rx_pause_valid);
   c_tx_pause: cover property (o_stat.tx_pause);
   c_tx_take: cover property (o_tx_ready && i_tx.valid);
endmodule
bind eth_lane_stat eth_lane_stat_asserts chk (.i_sys_clk, .i_srst, .i_mode_50g,
   .i_wide_user_bus, .i_test_pattern_en, .i_tx, .i_rx, .i_tx_pause_req, .o_tx_ready,
   .o_tx_pause_busy, .o_rx_pause_valid, .o_rx_lane_valid, .o_tx_lane_load, .o_stat,
   .o_active_lanes, .o_cfg_error);

// *** tb/eth_lane_stat_tb.sv ***
// self-checking bench for the lane, statistics and pause block
`timescale 1ns/1ps
module eth_lane_stat_tb;
   import eth_lane_pkg::*;
   typedef struct packed {logic [2:0] e; logic [4:0] x;} row_s;
   localparam row_s rows [5] = '{8'h14, 8'h8c, 8'h52, 8'h33, 8'heb};
   logic i_sys_clk = 1'b0, i_srst = 1'b1, mode = 1'b0, wide = 1'b0, tpat = 1'b0;
   logic [3:0] lock = 4'hf, lclk, lrst, load, lval;
   logic [3:0][63:0] ldata, sent, txd, rxw;
   logic tx_lock = 1'b1, refclk, refrst, ready, pbusy, pval, cfge;
   logic preq = 1'b0, pprio = 1'b0;
   logic [7:0] pen = 8'h0, ren;
   logic [15:0] pq = 16'h0;
   logic [47:0] psa = 48'h0;
   logic [7:0][15:0] rq;
   logic [2:0] act;
   logic [63:0] w [5];
   tx_word_s tx = '0;
   rx_word_s rx = '0;
   stat_s st;
   int fails = 0, compares = 0, cyc = 0;
   always #12.5 i_sys_clk = ~i_sys_clk;
   eth_lane_xcvr xcvr (.i_lock(lock), .i_tx_lock(tx_lock), .o_rx_clk(lclk), .o_rx_reset(lrst),
      .o_rx_data(ldata), .o_sent(sent), .o_tx_refclk(refclk), .o_tx_refclk_reset(refrst));
   eth_lane_stat uut (.i_sys_clk, .i_ce(1'b1), .i_srst, .i_mode_50g(mode),
      .i_wide_user_bus(wide), .i_test_pattern_en(tpat), .i_rx_lane_clk(lclk),
      .i_rx_lane_reset(lrst), .i_rx_lane_data(ldata), .i_tx_refclk(refclk),
      .i_tx_refclk_reset(refrst), .o_tx_lane_data(txd), .o_tx_lane_load(load),
      .o_rx_lane_word(rxw), .o_rx_lane_valid(lval), .i_tx(tx), .o_tx_ready(ready), .i_rx(rx),
      .i_tx_pause_req(preq), .i_tx_pause_prio(pprio), .i_tx_pause_enable(pen),
      .i_tx_pause_quanta(pq), .i_tx_pause_sa(psa), .o_tx_pause_busy(pbusy),
      .o_rx_pause_quanta(rq), .o_rx_pause_enable(ren), .o_rx_pause_valid(pval), .o_stat(st),
      .o_active_lanes(act), .o_cfg_error(cfge));
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic close_out();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge i_sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fails++;
         close_out();
      end
   end
   always @(negedge i_sys_clk)
      for (int l = 0; l < 4; l++)
         if (lval[l] === 1'b1) chk(rxw[l], sent[l]);
   task automatic grab(input int n, output stat_s s, output logic pv);
      s = '0;
      pv = 1'b0;
      repeat (n) begin
         @(negedge i_sys_clk);
         s = s | st;
         pv = pv | pval;
      end
   endtask
   task automatic rx_frame(input int n, input logic [1:0] e);
      for (int k = 0; k < n; k++) begin
         @(posedge i_sys_clk);
         rx <= '{1'b1, k == 0, k == n - 1, (k == n - 1) & e[1], (k == n - 1) & e[0], w[k]};
      end
      @(posedge i_sys_clk);
      rx <= '0;
   endtask
   task automatic tx_send(input logic err);
      @(posedge i_sys_clk);
      tx <= '{1'b1, 1'b1, 1'b1, err, 64'h1234_5678_9abc_def0};
      repeat (40) begin
         @(negedge i_sys_clk);
         if (ready === 1'b1) break;
      end
      @(posedge i_sys_clk);
      tx <= '0;
   endtask
   task automatic tx_pause(input logic pr);
      logic [63:0] got [8];
      logic [63:0] ex [8];
      int k;
      k = 0;
      ex = '{{48'h0180_c200_0001, 16'h0a1b}, {32'h2c3d_4e5f, 16'h8808, 7'h0, pr, 8'h01},
         pr ? {8'h0, 8'h3c, {3{16'h0abc}}} : {16'h0abc, 48'h0}, pr ? {4{16'h0abc}} : 64'h0,
         pr ? {16'h0abc, 48'h0} : 64'h0, 64'h0, 64'h0, 64'h0};
      @(posedge i_sys_clk);
      {preq, pprio, pen, pq, psa} <= {1'b1, pr, 8'h3c, 16'h0abc, 48'h0a1b_2c3d_4e5f};
      @(posedge i_sys_clk);
      preq <= 1'b0;
      repeat (200) begin
         @(negedge i_sys_clk);
         for (int l = 0; l < 4; l++)
            if (load[l] === 1'b1 && k < 8) begin
               got[k] = txd[l];
               k++;
            end
         if (st.tx_pause === 1'b1) break;
      end
      for (int j = 0; j < 8; j++)
         chk(got[j], ex[j]);
      chk({st.tx_pause, k[3:0]}, {1'b1, 4'h8});
   endtask
   task automatic lane_run(input logic m, input logic [3:0] lk, input logic [7:0] ex);
      logic [3:0] seen;
      @(posedge i_sys_clk);
      {mode, lock, wide} <= {m, lk, 1'b1};
      repeat (30) @(posedge i_sys_clk);
      seen = 4'h0;
      repeat (80) begin
         @(negedge i_sys_clk);
         seen = seen | lval;
      end
      chk({seen, act, cfge}, ex);
   endtask
   initial begin
      stat_s s;
      logic pv;
      repeat (3) @(negedge i_sys_clk);
      chk({st, ready, pval}, 0);
      repeat (2) @(posedge i_sys_clk);
      i_srst <= 1'b0;
      $display("reset test done");
      w = '{default: 64'h0011_2233_4455_6677};
      foreach (rows[i]) begin
         tx_send(rows[i].e[2]);
         grab(16, s, pv);
         chk({s.tx_good, s.tx_bad}, rows[i].x[4:3]);
         rx_frame(1, rows[i].e[1:0]);
         grab(4, s, pv);
         chk({s.rx_good, s.rx_bad, s.rx_len_err}, rows[i].x[2:0]);
         chk({s.tx_good, s.tx_bad, pv}, 0);
         $display("row %0d done", i);
      end
      w = '{{48'h0180_c200_0001, 16'h1122}, {32'h3344_5566, 16'h8808, 16'h0001},
         {16'hbeef, 48'h0}, {4{16'h1003}}, {16'h1007, 48'h0}};
      rx_frame(3, 2'b00);
      grab(4, s, pv);
      chk({pv, s.rx_pause, rq[0]}, {2'b11, 16'hbeef});
      w[1][15:0] = 16'h0101;
      w[2] = {8'h0, 8'ha5, 16'h1000, 16'h1001, 16'h1002};
      w[3] = {16'h1003, 16'h1004, 16'h1005, 16'h1006};
      rx_frame(5, 2'b00);
      grab(4, s, pv);
      chk({pv, ren}, {1'b1, 8'ha5});
      for (int k = 0; k < 8; k++)
         chk(rq[k], 16'h1000 + k);
      w[1][15:0] = 16'h0001;
      w[2] = 64'hdead_0000_0000_0000;
      rx_frame(3, 2'b10);
      grab(4, s, pv);
      chk({pv, s.rx_bad, s.rx_pause, rq[0]}, {3'b011, 16'h1000});
      $display("rx pause test done");
      for (int p = 0; p < 2; p++)
         tx_pause(p[0]);
      $display("tx pause test done");
      lane_run(1'b1, 4'hd, {4'h1, 3'h2, 1'b1});
      lane_run(1'b0, 4'hf, {4'hf, 3'h4, 1'b0});
      $display("lane test done");
      @(posedge i_sys_clk);
      tpat <= 1'b1;
      repeat (3) @(negedge i_sys_clk);
      grab(40, s, pv);
      chk(|s.test_err, 1);
      $display("test pattern test done");
      @(posedge i_sys_clk);
      {tpat, i_srst} <= 2'b01;
      repeat (2) @(negedge i_sys_clk);
      chk({st, load, lval, pval, ready}, 0);
      repeat (4) @(posedge i_sys_clk);
      i_srst <= 1'b0;
      tx_send(1'b0);
      grab(16, s, pv);
      chk({s.tx_good, s.tx_bad}, 2'b10);
      $display("second reset test done");
      close_out();
   end
endmodule

// *** tb/eth_lane_xcvr.sv ***
// transceiver model: recovered lane clocks and words, tx reference clock
`timescale 1ns/1ps
module eth_lane_xcvr (
   // lock controls
   input wire logic [3:0] i_lock,
   input wire logic i_tx_lock,
   // lane side
   output logic [3:0] o_rx_clk,
   output logic [3:0] o_rx_reset,
   output logic [3:0][63:0] o_rx_data,
   output logic [3:0][63:0] o_sent,
   // tx reference
   output logic o_tx_refclk,
   output logic o_tx_refclk_reset
);
   assign o_rx_reset = ~i_lock;
   assign o_tx_refclk_reset = ~i_tx_lock;
   initial begin
      o_tx_refclk = 1'b0;
      forever #100 o_tx_refclk = ~o_tx_refclk;
   end
   for (genvar l = 0; l < 4; l++) begin : g_lane
      logic [31:0] n;
      initial begin
         n = 32'h0;
         o_rx_clk[l] = 1'b0;
         o_rx_data[l] = 64'h0;
         o_sent[l] = 64'h0;
         #(7 + 31 * l);
         forever begin
            #100 o_rx_clk[l] = 1'b1;
            o_sent[l] = o_rx_data[l];
            #100 o_rx_clk[l] = 1'b0;
            n = n + 32'h1;
            o_rx_data[l] = {8'(l), n[23:0], ~n};
         end
      end
   end
endmodule

// *** verilog/eth_lane_pkg.sv ***
// types for the lane, statistics and pause block
package eth_lane_pkg;
   typedef struct packed {
      logic valid;
      logic sop;
      logic eop;
      logic err;
      logic [63:0] data;
   } tx_word_s;
   typedef struct packed {
      logic valid;
      logic sop;
      logic eop;
      logic fcs_err;
      logic len_err;
      logic [63:0] data;
   } rx_word_s;
   typedef struct packed {
      logic tx_good;
      logic tx_bad;
      logic tx_pause;
      logic rx_good;
      logic rx_bad;
      logic rx_len_err;
      logic rx_pause;
      logic [3:0] test_err;
   } stat_s;
   typedef enum logic [1:0] {TX_IDLE, TX_USER, TX_PAUSE} tx_state_e;
endpackage

// *** verilog/eth_lane_regs.svh ***
// constants for the lane, statistics and pause block
`ifndef ETH_LANE_REGS_SVH
`define ETH_LANE_REGS_SVH
`define LANE_MAX 4
`define LANES_40G 4
`define LANES_50G 2
`define VIRTUAL_LANE_COUNT 4
`define LANE_WORD_W 64
`define USER_BUS_W 128
`define USER_BUS_W_40G_WIDE 256
`define CORE_MHZ_40G 312.5
`define CORE_MHZ_50G 390.625
`define SCR_W 58
`define SCR_TAP_A 38
`define SCR_TAP_B 57
`define SCR_SEED 58'h3ff_ffff_ffff_ffff
`define PAUSE_DA 48'h0180_c200_0001
`define PAUSE_ETYPE 16'h8808
`define PAUSE_OP_GLOBAL 16'h0001
`define PAUSE_OP_PRIO 16'h0101
`define PAUSE_WORDS 8
`define PAUSE_CLASSES 8
`endif

// *** verilog/eth_lane_stat.sv ***
// lane-facing datapath with statistics pulses, pause handling and test patterns
`timescale 1ns/1ps
`include "eth_lane_regs.svh"
// How it works
// - each statistic has its own per-cycle increment output
// - transmit frames with any error count bad, otherwise good
// - receive length errors make a frame bad
// - receive pause frames are parsed and their quanta presented
// - requested global or priority pause frames are inserted into transmit
// - lanes carry scrambled test patterns and checkers flag mismatching words
// - core rate is 312.5 MHz at 40G and 390.625 MHz at 50G
// - two lanes at 50G, four at 40G, four virtual lanes always
// - receive lane word msb is earliest received bit
// - transmit lane word msb is sent first
// - each receive word is taken on its own lane clock rising edge
// - user stream is 128 bits straddled, 256 bits only at 40G
// - with optional registers some controls move out of broadside ports
module eth_lane_stat
   import eth_lane_pkg::*;
(
   // clock, enable, reset
   input wire logic i_sys_clk,
   input wire logic i_ce,
   input wire logic i_srst,
   // mode and test controls
   input wire logic i_mode_50g,
   input wire logic i_wide_user_bus,
   input wire logic i_test_pattern_en,
   // receive lanes from transceivers
   input wire logic [3:0] i_rx_lane_clk,
   input wire logic [3:0] i_rx_lane_reset,
   input wire logic [3:0][63:0] i_rx_lane_data,
   // transmit reference from transceivers
   input wire logic i_tx_refclk,
   input wire logic i_tx_refclk_reset,
   // transmit lanes to transceivers
   output logic [3:0][63:0] o_tx_lane_data,
   output logic [3:0] o_tx_lane_load,
   // received lane words
   output logic [3:0][63:0] o_rx_lane_word,
   output logic [3:0] o_rx_lane_valid,
   // framed streams
   input wire tx_word_s i_tx,
   output logic o_tx_ready,
   input wire rx_word_s i_rx,
   // pause control and status
   input wire logic i_tx_pause_req,
   input wire logic i_tx_pause_prio,
   input wire logic [7:0] i_tx_pause_enable,
   input wire logic [15:0] i_tx_pause_quanta,
   input wire logic [47:0] i_tx_pause_sa,
   output logic o_tx_pause_busy,
   output logic [7:0][15:0] o_rx_pause_quanta,
   output logic [7:0] o_rx_pause_enable,
   output logic o_rx_pause_valid,
   // statistics and configuration status
   output stat_s o_stat,
   output logic [2:0] o_active_lanes,
   output logic o_cfg_error
);

   logic [3:0] active_mask;
   logic [3:0][2:0] rclk_sync_r;
   logic [3:0][1:0] rrst_sync_r;
   logic [3:0][1:0][63:0] rdat_sync_r;
   logic [3:0] rx_edge;
   logic [2:0] tclk_sync_r;
   logic [1:0] trst_sync_r;
   logic tx_edge;
   logic [3:0][57:0] tp_gen_r;
   logic [3:0][57:0] tp_chk_r;
   logic [3:0][121:0] gen_step;
   logic [7:0][15:0] rx_q_nxt;
   logic [7:0] rx_en_nxt;
   logic [3:0] tp_err_nxt;
   tx_state_e tx_state_r;
   logic [1:0] tx_lane_r;
   logic [2:0] pw_idx_r;
   logic pause_pend_r;
   logic pause_prio_r;
   logic [7:0] pause_en_r;
   logic [15:0] pause_q_r;
   logic [47:0] pause_sa_r;
   logic [63:0] tx_word;
   logic tx_word_ok;
   logic tx_word_pause;
   logic [2:0] rx_idx_r;
   logic rx_is_pause_r;
   logic rx_is_prio_r;
   logic [7:0][15:0] rx_q_r;
   logic [7:0] rx_en_r;
   logic tx_last_pause;

   // scrambler step over one word, msb first, returns {state, word}
   function automatic logic [121:0] scr_word(input logic [57:0] st, input logic [63:0] d,
                                            input logic descr);
      logic [57:0] s;
      logic [63:0] o;
      logic b;
      s = st;
      o = 64'h0;
      for (int i = 63; i >= 0; i--) begin
         b = d[i] ^ s[`SCR_TAP_A] ^ s[`SCR_TAP_B];
         o[i] = b;
         s = {s[56:0], (descr ? d[i] : b)};
      end
      return {s, o};
   endfunction

   // pause frame word by index
   function automatic logic [63:0] pause_word(input logic [2:0] idx, input logic prio,
                                             input logic [7:0] en, input logic [15:0] q,
                                             input logic [47:0] sa);
      logic [63:0] w;
      w = 64'h0;
      case (idx)
         3'h0: w = {`PAUSE_DA, sa[47:32]};
         3'h1: w = {sa[31:0], `PAUSE_ETYPE, (prio ? `PAUSE_OP_PRIO : `PAUSE_OP_GLOBAL)};
         3'h2: w = prio ? {8'h00, en, q, q, q} : {q, 48'h0};
         3'h3: w = prio ? {q, q, q, q} : 64'h0;
         3'h4: w = prio ? {q, 48'h0} : 64'h0;
         default: w = 64'h0;
      endcase
      return w;
   endfunction

   // lane count and user bus legality per rate
   always_comb begin
      active_mask = i_mode_50g ? 4'h3 : 4'hf;
      o_active_lanes = i_mode_50g ? 3'(`LANES_50G) : 3'(`LANES_40G);
      o_cfg_error = i_mode_50g & i_wide_user_bus;
   end

   // receive lane clocks through three flops, resets and data through two flops each
   genvar g;
   generate
      for (g = 0; g < `LANE_MAX; g++) begin : g_rx
         always_ff @(posedge i_sys_clk) begin
            if (i_srst) begin
               rclk_sync_r[g] <= 3'h0;
               rrst_sync_r[g] <= 2'h3;
               rdat_sync_r[g] <= '0;
            end else if (i_ce) begin
               rclk_sync_r[g] <= {rclk_sync_r[g][1:0], i_rx_lane_clk[g]};
               rrst_sync_r[g] <= {rrst_sync_r[g][0], i_rx_lane_reset[g]};
               rdat_sync_r[g] <= {rdat_sync_r[g][0], i_rx_lane_data[g]};
            end
         end
         assign rx_edge[g] = rclk_sync_r[g][1] & ~rclk_sync_r[g][2];

         // lane word capture on its own clock edge
         always_ff @(posedge i_sys_clk) begin
            if (i_srst) begin
               o_rx_lane_word[g] <= 64'h0;
               o_rx_lane_valid[g] <= 1'b0;
            end else if (i_ce) begin
               o_rx_lane_valid[g] <= 1'b0;
               if (rx_edge[g] && !rrst_sync_r[g][1] && active_mask[g]) begin
                  o_rx_lane_word[g] <= rdat_sync_r[g][1];
                  o_rx_lane_valid[g] <= 1'b1;
               end
            end
         end

         // test pattern checker, self-synchronising descrambler
         logic [121:0] chk_step;
         assign chk_step = scr_word(tp_chk_r[g], rdat_sync_r[g][1], 1'b1);
         assign gen_step[g] = scr_word(tp_gen_r[g], 64'h0, 1'b0);
         always_comb begin
            tp_err_nxt[g] = 1'b0;
            if (i_test_pattern_en && rx_edge[g] && !rrst_sync_r[g][1] && active_mask[g]) begin
               tp_err_nxt[g] = |chk_step[63:0];
            end
         end
         always_ff @(posedge i_sys_clk) begin
            if (i_srst || rrst_sync_r[g][1]) begin
               tp_chk_r[g] <= `SCR_SEED;
            end else if (i_ce && rx_edge[g]) begin
               tp_chk_r[g] <= chk_step[121:64];
            end
         end

         // test pattern generator, scrambled zero stream per lane
         always_ff @(posedge i_sys_clk) begin
            if (i_srst || trst_sync_r[1]) begin
               tp_gen_r[g] <= `SCR_SEED;
            end else if (i_ce && tx_edge && i_test_pattern_en) begin
               tp_gen_r[g] <= gen_step[g][121:64];
            end
         end
      end
   endgenerate

   // transmit reference clock and reset sampling
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         tclk_sync_r <= 3'h0;
         trst_sync_r <= 2'h3;
      end else if (i_ce) begin
         tclk_sync_r <= {tclk_sync_r[1:0], i_tx_refclk};
         trst_sync_r <= {trst_sync_r[0], i_tx_refclk_reset};
      end
   end
   assign tx_edge = tclk_sync_r[1] & ~tclk_sync_r[2] & ~trst_sync_r[1];

   // pause request latch, held until the frame starts
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         pause_pend_r <= 1'b0;
         pause_prio_r <= 1'b0;
         pause_en_r <= 8'h0;
         pause_q_r <= 16'h0;
         pause_sa_r <= 48'h0;
      end else if (i_ce) begin
         if (i_tx_pause_req && !pause_pend_r && tx_state_r != TX_PAUSE) begin
            pause_pend_r <= 1'b1;
            pause_prio_r <= i_tx_pause_prio;
            pause_en_r <= i_tx_pause_enable;
            pause_q_r <= i_tx_pause_quanta;
            pause_sa_r <= i_tx_pause_sa;
         end else if (tx_edge && tx_state_r == TX_IDLE && pause_pend_r) begin
            pause_pend_r <= 1'b0;
         end
      end
   end
   assign o_tx_pause_busy = pause_pend_r | (tx_state_r == TX_PAUSE);

   // user stream is taken only between pause frames and on a lane slot
   assign o_tx_ready = tx_edge & ~i_test_pattern_en &
                       (tx_state_r == TX_USER | (tx_state_r == TX_IDLE & ~pause_pend_r));
   assign tx_word_pause = (tx_state_r == TX_PAUSE);
   assign tx_last_pause = tx_word_pause && pw_idx_r == 3'(`PAUSE_WORDS - 1);
   always_comb begin
      tx_word = 64'h0;
      tx_word_ok = 1'b0;
      if (tx_word_pause) begin
         tx_word = pause_word(pw_idx_r, pause_prio_r, pause_en_r, pause_q_r, pause_sa_r);
         tx_word_ok = tx_edge;
      end else if (o_tx_ready && i_tx.valid) begin
         tx_word = i_tx.data;
         tx_word_ok = 1'b1;
      end
   end

   // transmit frame scheduler
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         tx_state_r <= TX_IDLE;
         pw_idx_r <= 3'h0;
      end else if (i_ce && tx_edge) begin
         case (tx_state_r)
            TX_IDLE: begin
               pw_idx_r <= 3'h0;
               if (pause_pend_r) begin
                  tx_state_r <= TX_PAUSE;
               end else if (o_tx_ready && i_tx.valid && i_tx.sop && !i_tx.eop) begin
                  tx_state_r <= TX_USER;
               end
            end
            TX_USER: begin
               if (i_tx.valid && i_tx.eop) begin
                  tx_state_r <= TX_IDLE;
               end
            end
            TX_PAUSE: begin
               pw_idx_r <= pw_idx_r + 3'h1;
               if (tx_last_pause) begin
                  tx_state_r <= TX_IDLE;
               end
            end
            default: tx_state_r <= TX_IDLE;
         endcase
      end
   end

   // transmit lane loading, round robin over active lanes, all active lanes at once in test pattern mode
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         o_tx_lane_data <= '0;
         o_tx_lane_load <= 4'h0;
         tx_lane_r <= 2'h0;
      end else if (i_ce) begin
         o_tx_lane_load <= 4'h0;
         if (tx_edge && i_test_pattern_en) begin
            for (int l = 0; l < `LANE_MAX; l++) begin
               o_tx_lane_data[l] <= gen_step[l][63:0];
            end
            o_tx_lane_load <= active_mask;
         end else if (tx_word_ok) begin
            o_tx_lane_data[tx_lane_r] <= tx_word;
            o_tx_lane_load[tx_lane_r] <= 1'b1;
            tx_lane_r <= (tx_lane_r == 2'(o_active_lanes - 3'h1)) ? 2'h0 : tx_lane_r + 2'h1;
         end
      end
   end

   // quanta as they stand after this word, so the closing word counts too
   always_comb begin
      rx_q_nxt = rx_q_r;
      rx_en_nxt = rx_en_r;
      if (!i_rx.sop && rx_idx_r == 3'h2) begin
         if (rx_is_prio_r) begin
            rx_en_nxt = i_rx.data[55:48];
            rx_q_nxt[0] = i_rx.data[47:32];
            rx_q_nxt[1] = i_rx.data[31:16];
            rx_q_nxt[2] = i_rx.data[15:0];
         end else begin
            rx_en_nxt = 8'hff;
            rx_q_nxt = {8{i_rx.data[63:48]}};
         end
      end else if (!i_rx.sop && rx_idx_r == 3'h3 && rx_is_prio_r) begin
         rx_q_nxt[3] = i_rx.data[63:48];
         rx_q_nxt[4] = i_rx.data[47:32];
         rx_q_nxt[5] = i_rx.data[31:16];
         rx_q_nxt[6] = i_rx.data[15:0];
      end else if (!i_rx.sop && rx_idx_r == 3'h4 && rx_is_prio_r) begin
         rx_q_nxt[7] = i_rx.data[63:48];
      end
   end

   // receive pause parser
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         rx_idx_r <= 3'h0;
         rx_is_pause_r <= 1'b0;
         rx_is_prio_r <= 1'b0;
         rx_q_r <= '0;
         rx_en_r <= 8'h0;
      end else if (i_ce && i_rx.valid) begin
         rx_idx_r <= i_rx.eop ? 3'h0 : (i_rx.sop ? 3'h1 : (rx_idx_r == 3'h7 ? 3'h7 : rx_idx_r + 3'h1));
         rx_q_r <= rx_q_nxt;
         rx_en_r <= rx_en_nxt;
         if (i_rx.sop) begin
            rx_is_pause_r <= (i_rx.data[63:16] == `PAUSE_DA);
         end else if (rx_idx_r == 3'h1) begin
            rx_is_pause_r <= rx_is_pause_r && i_rx.data[31:16] == `PAUSE_ETYPE &&
               (i_rx.data[15:0] == `PAUSE_OP_GLOBAL || i_rx.data[15:0] == `PAUSE_OP_PRIO);
            rx_is_prio_r <= (i_rx.data[15:0] == `PAUSE_OP_PRIO);
         end
      end
   end

   // presented pause status, updated only by good pause frames
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         o_rx_pause_quanta <= '0;
         o_rx_pause_enable <= 8'h0;
         o_rx_pause_valid <= 1'b0;
      end else if (i_ce) begin
         o_rx_pause_valid <= 1'b0;
         if (i_rx.valid && i_rx.eop && rx_is_pause_r && !i_rx.sop &&
             !i_rx.fcs_err && !i_rx.len_err) begin
            o_rx_pause_quanta <= rx_q_nxt;
            o_rx_pause_enable <= rx_en_nxt;
            o_rx_pause_valid <= 1'b1;
         end
      end
   end

   // statistics increments, zero unless an event occurs
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         o_stat <= '0;
      end else if (i_ce) begin
         o_stat <= '0;
         if (o_tx_ready && i_tx.valid && i_tx.eop) begin
            o_stat.tx_good <= ~i_tx.err;
            o_stat.tx_bad <= i_tx.err;
         end
         o_stat.tx_pause <= tx_edge & tx_last_pause;
         if (i_rx.valid && i_rx.eop) begin
            o_stat.rx_good <= ~(i_rx.fcs_err | i_rx.len_err);
            o_stat.rx_bad <= i_rx.fcs_err | i_rx.len_err;
            o_stat.rx_len_err <= i_rx.len_err;
            o_stat.rx_pause <= rx_is_pause_r & ~i_rx.sop;
         end
         o_stat.test_err <= tp_err_nxt;
      end
   end

endmodule
